// File: hw/tap_controller.sv
// Purpose: Test access port with bypass, clamp, identification, capture
// Assumes: Test pins sampled by clk, well above the test clock rate
// Notes:   Boundary cells lie outside; only hold/high-z controls leave
//
// Functional notes
// - Bypass sends TDI to TDO through one register, one shift of delay.
// - Capture-DR loads zero into the bypass register when it is selected.
// - Clamp holds boundary outputs and scans through the bypass register.
// - TAP reset by TRST low or five TMS-high clocks loads identification.
// - The identification value ends in a one, shifted out first.
// - A bypass register exists and is not the default after reset.
// - Identification shifts out 32 bits, least significant bit first.
// - Identification holds one, maker code, part code and revision.
// - Capture-IR loads the capture pattern whose low bits are 01.
// - Six-bit instruction shifts in, takes effect only at Update-IR.
// - Bypass is all six bits set and selects the bypass path.
// - Identification is 000010 and selects the identification register.
// - Clamp is 111110, holds outputs as extest, scans through bypass.
`timescale 1ns/1ps
module tap_controller #(
  parameter logic [10:0] MAKER_CODE = 11'h2A5,  // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A3C, // Arbitrary value
  parameter logic [3:0]  REVISION   = 4'h1      // Arbitrary value
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  input  wire logic                         trst_n,
  output logic                              tdo,
  output logic                              tdo_oe_n,
  output logic [tap_pkg::IR_WIDTH-1:0]      instruction,
  output logic                              boundary_hold,
  output logic                              boundary_highz
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin sampling
  logic                rst_meta;
  logic                rst_sync_n;
  tap_pkg::tap_pins_s  pins;
  logic [3:0]          pins_raw;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  pin_sync #(
    .WIDTH       (4),
    .RESET_VALUE (tap_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_sync_n),
    .pin_in ({trst_n, tck, tms, tdi}),
    .level  (pins_raw)
  );

  assign pins = tap_pkg::tap_pins_s'(pins_raw);

  ////////////////////////////////////////////////////////////////////////
  // Identification value
  localparam tap_pkg::id_value_s ID_VALUE = '{
    revision:         REVISION,
    part_code:        PART_CODE,
    maker_code_field: MAKER_CODE,
    fixed_one:        1'b1
  };

  ////////////////////////////////////////////////////////////////////////
  // TAP state walk
  function automatic tap_pkg::tap_state_e step(
    input tap_pkg::tap_state_e s,
    input logic                m
  );
    unique case (s)
      tap_pkg::ST_LOGIC_RESET: step = m ? tap_pkg::ST_LOGIC_RESET
                                        : tap_pkg::ST_RUN_IDLE;
      tap_pkg::ST_RUN_IDLE:    step = m ? tap_pkg::ST_SELECT_DR
                                        : tap_pkg::ST_RUN_IDLE;
      tap_pkg::ST_SELECT_DR:   step = m ? tap_pkg::ST_SELECT_IR
                                        : tap_pkg::ST_CAPTURE_DR;
      tap_pkg::ST_CAPTURE_DR:  step = m ? tap_pkg::ST_EXIT1_DR
                                        : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_SHIFT_DR:    step = m ? tap_pkg::ST_EXIT1_DR
                                        : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_EXIT1_DR:    step = m ? tap_pkg::ST_UPDATE_DR
                                        : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_PAUSE_DR:    step = m ? tap_pkg::ST_EXIT2_DR
                                        : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_EXIT2_DR:    step = m ? tap_pkg::ST_UPDATE_DR
                                        : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_UPDATE_DR:   step = m ? tap_pkg::ST_SELECT_DR
                                        : tap_pkg::ST_RUN_IDLE;
      tap_pkg::ST_SELECT_IR:   step = m ? tap_pkg::ST_LOGIC_RESET
                                        : tap_pkg::ST_CAPTURE_IR;
      tap_pkg::ST_CAPTURE_IR:  step = m ? tap_pkg::ST_EXIT1_IR
                                        : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_SHIFT_IR:    step = m ? tap_pkg::ST_EXIT1_IR
                                        : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_EXIT1_IR:    step = m ? tap_pkg::ST_UPDATE_IR
                                        : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_PAUSE_IR:    step = m ? tap_pkg::ST_EXIT2_IR
                                        : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_EXIT2_IR:    step = m ? tap_pkg::ST_UPDATE_IR
                                        : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_UPDATE_IR:   step = m ? tap_pkg::ST_SELECT_DR
                                        : tap_pkg::ST_RUN_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  tap_pkg::tap_state_e          state,    next_state;
  logic [tap_pkg::IR_WIDTH-1:0] ir_shift, next_ir_shift;
  logic [tap_pkg::IR_WIDTH-1:0] next_instruction;
  logic                         bypass,   next_bypass;
  logic [tap_pkg::ID_WIDTH-1:0] id_shift, next_id_shift;
  logic                         tck_prev;
  logic                         next_tdo, next_tdo_oe_n;
  logic [2:0]                   tms_cnt,  next_tms_cnt;
  logic                         tck_rise, tck_fall, sel_id;
  logic                         id_first, next_id_first;

  assign tck_rise = pins.tck & ~tck_prev;
  assign tck_fall = ~pins.tck & tck_prev;
  assign sel_id   = (instruction == tap_pkg::OP_IDCODE);

  always_comb begin
    next_state       = state;
    next_ir_shift    = ir_shift;
    next_instruction = instruction;
    next_bypass      = bypass;
    next_id_shift    = id_shift;
    next_tdo         = tdo;
    next_tdo_oe_n    = tdo_oe_n;
    next_tms_cnt     = tms_cnt;
    if (!pins.trst_n) begin
      next_state    = tap_pkg::ST_LOGIC_RESET;
      next_tdo_oe_n = 1'b1;
      next_tms_cnt  = '0;
    end else begin
      if (tck_rise) begin
        next_state   = step(state, pins.tms);
        next_tms_cnt = !pins.tms ? 3'h0 :
                       (tms_cnt == tap_pkg::TMS_RESET_COUNT) ? tms_cnt :
                       tms_cnt + 3'h1;
        unique case (state)
          tap_pkg::ST_CAPTURE_DR: begin
            next_bypass   = 1'b0;
            next_id_shift = ID_VALUE;
          end
          tap_pkg::ST_SHIFT_DR: begin
            if (sel_id) begin
              next_id_shift = {pins.tdi, id_shift[tap_pkg::ID_WIDTH-1:1]};
            end else begin
              next_bypass = pins.tdi;
            end
          end
          tap_pkg::ST_CAPTURE_IR: begin
            next_ir_shift = tap_pkg::OP_VALIDATE;
          end
          tap_pkg::ST_SHIFT_IR: begin
            next_ir_shift = {pins.tdi, ir_shift[tap_pkg::IR_WIDTH-1:1]};
          end
          tap_pkg::ST_UPDATE_IR: begin
            next_instruction = ir_shift;
          end
          default: ;
        endcase
      end
      // TDO changes on the falling edge so the far end samples it stable
      if (tck_fall) begin
        next_tdo_oe_n = !(state == tap_pkg::ST_SHIFT_DR ||
                          state == tap_pkg::ST_SHIFT_IR);
        if (state == tap_pkg::ST_SHIFT_IR) begin
          next_tdo = ir_shift[0];
        end else if (sel_id) begin
          next_tdo = id_shift[0];
        end else begin
          next_tdo = bypass;
        end
      end
    end
    if (next_state == tap_pkg::ST_LOGIC_RESET) begin
      next_instruction = tap_pkg::OP_IDCODE;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state          <= tap_pkg::ST_LOGIC_RESET;
      ir_shift       <= tap_pkg::OP_IDCODE;
      instruction    <= tap_pkg::OP_IDCODE;
      bypass         <= 1'b0;
      id_shift       <= '0;
      tck_prev       <= 1'b0;
      tdo            <= 1'b0;
      tdo_oe_n       <= 1'b1;
      tms_cnt        <= '0;
      id_first       <= 1'b0;
      boundary_hold  <= 1'b0;
      boundary_highz <= 1'b0;
    end else begin
      state          <= next_state;
      ir_shift       <= next_ir_shift;
      instruction    <= next_instruction;
      bypass         <= next_bypass;
      id_shift       <= next_id_shift;
      tck_prev       <= pins.tck;
      tdo            <= next_tdo;
      tdo_oe_n       <= next_tdo_oe_n;
      tms_cnt        <= next_tms_cnt;
      id_first       <= next_id_first;
      boundary_hold  <= (next_instruction == tap_pkg::OP_CLAMP) ||
                        (next_instruction == tap_pkg::OP_EXTEST);
      boundary_highz <= (next_instruction == tap_pkg::OP_HIGHZ);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  // Pending first fall after an identification capture; test reset drops it
  assign next_id_first = (id_first && !tck_fall && pins.trst_n) ||
                         (tck_rise && pins.trst_n && sel_id &&
                          state == tap_pkg::ST_CAPTURE_DR);

  sequence seq_bypass_capture;
    tck_rise && state == tap_pkg::ST_CAPTURE_DR && !sel_id && pins.trst_n;
  endsequence
  sequence seq_bypass_shift;
    tck_rise && state == tap_pkg::ST_SHIFT_DR && !sel_id && pins.trst_n;
  endsequence
  sequence seq_id_capture;
    tck_rise && state == tap_pkg::ST_CAPTURE_DR && sel_id && pins.trst_n;
  endsequence
  a_bypass_capture_zero: assert property (
    seq_bypass_capture |=> bypass == 1'b0)
    else $error("bypass not cleared at capture");
  a_bypass_one_shift: assert property (
    seq_bypass_shift |=> bypass == $past(pins.tdi))
    else $error("bypass did not take tdi");
  a_clamp_path: assert property (
    instruction == tap_pkg::OP_CLAMP |-> !sel_id && boundary_hold)
    else $error("clamp not holding or not on bypass");
  a_bypass_decode: assert property (
    instruction == tap_pkg::OP_BYPASS |-> !sel_id && !boundary_hold)
    else $error("bypass code decoded wrongly");
  a_reset_loads_id: assert property (
    state == tap_pkg::ST_LOGIC_RESET |-> instruction == tap_pkg::OP_IDCODE
                                         && sel_id)
    else $error("reset did not select identification");
  a_tms_five_reset: assert property (
    tms_cnt == tap_pkg::TMS_RESET_COUNT |-> state == tap_pkg::ST_LOGIC_RESET)
    else $error("five tms highs did not reset");
  a_trst_forces_reset: assert property (
    !pins.trst_n |=> state == tap_pkg::ST_LOGIC_RESET && tdo_oe_n)
    else $error("trst did not reset state");
  a_id_capture_value: assert property (
    seq_id_capture |=> id_shift == ID_VALUE && id_shift[0] == 1'b1)
    else $error("identification capture wrong");
  a_id_lsb_first: assert property (
    id_first && tck_fall && pins.trst_n |=> tdo == 1'b1)
    else $error("first identification bit not one");
  a_capture_ir_pattern: assert property (
    tck_rise && state == tap_pkg::ST_CAPTURE_IR && pins.trst_n
    |=> ir_shift[1:0] == 2'b01)
    else $error("capture pattern wrong");
  a_update_ir_only: assert property (
    $changed(instruction) |-> $past(state) == tap_pkg::ST_UPDATE_IR ||
                              state == tap_pkg::ST_LOGIC_RESET)
    else $error("instruction changed outside update");
endmodule

// File: shared/tap_pkg.sv
// Purpose: Shared constants and types for the test access port logic
// Assumes: Six-bit instruction register, 32-bit identification value
// Notes:   Opcodes limited to those this block decodes, plus SAMPLE, which it runs as bypass
package tap_pkg;

  localparam int IR_WIDTH = 6;
  localparam int ID_WIDTH = 32;

  localparam logic [IR_WIDTH-1:0] OP_EXTEST   = 6'h00;
  localparam logic [IR_WIDTH-1:0] OP_SAMPLE   = 6'h01;
  localparam logic [IR_WIDTH-1:0] OP_IDCODE   = 6'h02;
  localparam logic [IR_WIDTH-1:0] OP_HIGHZ    = 6'h03;
  localparam logic [IR_WIDTH-1:0] OP_VALIDATE = 6'h2D;
  localparam logic [IR_WIDTH-1:0] OP_CLAMP    = 6'h3E;
  localparam logic [IR_WIDTH-1:0] OP_BYPASS   = 6'h3F;

  // Field positions of the identification value
  localparam int ID_ONE_BIT      = 0;
  localparam int ID_MAKER_LSB    = 1;
  localparam int ID_MAKER_WIDTH  = 11;
  localparam int ID_PART_LSB     = 12;
  localparam int ID_PART_WIDTH   = 16;
  localparam int ID_REV_LSB      = 28;
  localparam int ID_REV_WIDTH    = 4;

  // Consecutive TMS-high rising edges that always reach reset
  localparam logic [2:0] TMS_RESET_COUNT = 3'h5;

  // Reset value of synchronised pins: trst_n low, tck low, tms/tdi high
  localparam logic [3:0] PIN_RESET = 4'h3;

  typedef enum logic [3:0] {
    ST_EXIT2_DR      = 4'b0000,
    ST_EXIT1_DR      = 4'b0001,
    ST_SHIFT_DR      = 4'b0010,
    ST_PAUSE_DR      = 4'b0011,
    ST_SELECT_IR     = 4'b0100,
    ST_UPDATE_DR     = 4'b0101,
    ST_CAPTURE_DR    = 4'b0110,
    ST_SELECT_DR     = 4'b0111,
    ST_EXIT2_IR      = 4'b1000,
    ST_EXIT1_IR      = 4'b1001,
    ST_SHIFT_IR      = 4'b1010,
    ST_PAUSE_IR      = 4'b1011,
    ST_RUN_IDLE      = 4'b1100,
    ST_UPDATE_IR     = 4'b1101,
    ST_CAPTURE_IR    = 4'b1110,
    ST_LOGIC_RESET   = 4'b1111
  } tap_state_e;

  typedef struct packed {
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_s;

  typedef struct packed {
    logic [ID_REV_WIDTH-1:0]   revision;
    logic [ID_PART_WIDTH-1:0]  part_code;
    logic [ID_MAKER_WIDTH-1:0] maker_code_field;
    logic                      fixed_one;
  } id_value_s;

endpackage

// File: hw/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for test pins
// Assumes: Inputs are asynchronous to clk
// Notes:   Level changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH       = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  // Stage one feeds stage two only, to contain metastability
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      level  <= RESET_VALUE;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule

// File: verif/test_controller.sv
// Purpose: Board test controller model driving the serial test port
// Assumes: Called from a clk rising edge; one test clock is 8 clk
// Notes:   Pins change only by non-blocking assignment at clk edges
`timescale 1ns/1ps
module test_controller (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  ////////////////////////////////////////////////////////////////////////
  // idle: held in reset, clock low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic hold_trst(input logic lvl);
    trst_n <= lvl;
    wait_clk(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Data out is taken late in the high phase, well after it settled
  task automatic bit_cycle(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    wait_clk(4);
    tck <= 1'b1;
    wait_clk(3);
    q = tdo;
    wait_clk(1);
    tck <= 1'b0;
  endtask

  // Mode select pattern, first move in bit 0; data line left at pull-up
  task automatic moves(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      bit_cycle(pat[i], 1'b1, q);
    end
  endtask

  // From Run-Idle through a 32-bit data scan back to Run-Idle
  task automatic scan_dr(input logic [31:0] din, output logic [31:0] dout);
    logic q;
    moves(8'h01, 3);
    for (int i = 0; i < 32; i++) begin
      bit_cycle(i == 31, din[i], q);
      dout[i] = q;
    end
    moves(8'h01, 2);
  endtask

  // From Run-Idle to Exit1-IR; update is a separate step
  task automatic ir_shift(input logic [5:0] op, output logic [5:0] cap);
    logic       q;
    logic [5:0] code;
    code = op;
    if (code inside {[6'h04:6'h2C], [6'h2E:6'h3D]}) begin
      code = tap_pkg::OP_BYPASS;
    end
    moves(8'h03, 4);
    for (int i = 0; i < 6; i++) begin
      bit_cycle(i == 5, code[i], q);
      cap[i] = q;
    end
  endtask

  task automatic ir_update;
    moves(8'h01, 2);
  endtask
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the test access port logic
// Assumes: 20 MHz clk, test clock 400 ns from the controller model
// Notes:   Identification parameters below are arbitrary values
`timescale 1ns/1ps
module testbench;
  localparam logic [10:0] MAKER = 11'h155;  // Arbitrary value
  localparam logic [15:0] PART  = 16'hC3A5; // Arbitrary value
  localparam logic [3:0]  REV   = 4'h6;     // Arbitrary value
  localparam logic [31:0] ID_EXP = {REV, PART, MAKER, 1'b1};
  localparam logic [31:0] PAT    = 32'hA5C3_0F96;

  typedef struct packed {
    logic [5:0] op;
    logic       hold;
    logic       highz;
    logic       id_path;
  } row_s;

  logic        clk;
  logic        reset_n;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst_n;
  logic        tdo;
  logic        tdo_oe_n;
  logic [5:0]  instruction;
  logic        boundary_hold;
  logic        boundary_highz;
  logic [31:0] word;
  logic [5:0]  cap;
  logic [5:0]  prev;
  int          n_fail = 0;
  int          n_tests = 0;

  row_s rows [6] = '{
    '{tap_pkg::OP_BYPASS, 1'b0, 1'b0, 1'b0},
    '{tap_pkg::OP_CLAMP,  1'b1, 1'b0, 1'b0},
    '{tap_pkg::OP_SAMPLE, 1'b0, 1'b0, 1'b0},
    '{tap_pkg::OP_EXTEST, 1'b1, 1'b0, 1'b0},
    '{tap_pkg::OP_HIGHZ,  1'b0, 1'b1, 1'b0},
    '{tap_pkg::OP_IDCODE, 1'b0, 1'b0, 1'b1}
  };

  tap_controller #(
    .MAKER_CODE (MAKER),
    .PART_CODE  (PART),
    .REVISION   (REV)
  ) dut (
    .clk            (clk),
    .reset_n        (reset_n),
    .tck            (tck),
    .tms            (tms),
    .tdi            (tdi),
    .trst_n         (trst_n),
    .tdo            (tdo),
    .tdo_oe_n       (tdo_oe_n),
    .instruction    (instruction),
    .boundary_hold  (boundary_hold),
    .boundary_highz (boundary_highz)
  );

  // Undriven tdo shows the inverse, so a late enable corrupts the scan
  test_controller ctl (
    .clk    (clk),
    .tdo    (tdo_oe_n ? ~tdo : tdo),
    .tck    (tck),
    .tms    (tms),
    .tdi    (tdi),
    .trst_n (trst_n)
  );

  ////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp,
                          input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic chk_ir(input logic [5:0] exp, input string what);
    chk_word({26'h0, instruction}, {26'h0, exp}, what);
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is near 3500 clk; over five times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    repeat (19) @(posedge clk);
    chk_ir(tap_pkg::OP_IDCODE, "reset instruction");
    chk_flag(tdo_oe_n, 1'b1, "reset oe");
    chk_flag(boundary_hold | boundary_highz, 1'b0, "reset hold");
    @(posedge clk);
    reset_n <= 1'b1;
    settle(8);
    ctl.hold_trst(1'b1);
    ctl.moves(8'h00, 1);
    ctl.scan_dr(PAT, word);
    chk_word(word, ID_EXP, "id after reset");
    prev = tap_pkg::OP_IDCODE;
    foreach (rows[k]) begin
      ctl.ir_shift(rows[k].op, cap);
      chk_ir(prev, "ir before update");
      chk_word({26'h0, cap}, {26'h0, tap_pkg::OP_VALIDATE}, "ir cap");
      ctl.ir_update;
      settle(4);
      chk_ir(rows[k].op, "ir after update");
      chk_flag(boundary_hold, rows[k].hold, "hold");
      chk_flag(boundary_highz, rows[k].highz, "highz");
      ctl.scan_dr(PAT, word);
      chk_word(word, rows[k].id_path ? ID_EXP : {PAT[30:0], 1'b0},
               "dr scan");
      prev = rows[k].op;
    end
    // Four ones from Shift-DR stop short of reset, the fifth reaches it
    ctl.ir_shift(tap_pkg::OP_BYPASS, cap);
    ctl.ir_update;
    ctl.moves(8'h01, 3);
    ctl.moves(8'h0F, 4);
    settle(4);
    chk_ir(tap_pkg::OP_BYPASS, "four ones");
    ctl.moves(8'h01, 1);
    settle(4);
    chk_ir(tap_pkg::OP_IDCODE, "five ones");
    // Test reset in mid-shift with the test clock standing low
    ctl.moves(8'h00, 1);
    ctl.ir_shift(tap_pkg::OP_CLAMP, cap);
    ctl.ir_update;
    ctl.moves(8'h01, 3);
    settle(6);
    chk_flag(tdo_oe_n, 1'b0, "oe in shift");
    ctl.hold_trst(1'b0);
    chk_ir(tap_pkg::OP_IDCODE, "trst instruction");
    chk_flag(tdo_oe_n, 1'b1, "trst oe");
    chk_flag(boundary_hold, 1'b0, "trst hold");
    ctl.hold_trst(1'b1);
    // System reset in mid-run after a clamp load
    ctl.moves(8'h00, 1);
    ctl.ir_shift(tap_pkg::OP_CLAMP, cap);
    ctl.ir_update;
    settle(4);
    chk_ir(tap_pkg::OP_CLAMP, "clamp before reset");
    reset_n <= 1'b0;
    settle(2);
    chk_ir(tap_pkg::OP_IDCODE, "instruction in reset");
    chk_flag(boundary_hold, 1'b0, "hold in reset");
    reset_n <= 1'b1;
    settle(10);
    ctl.moves(8'h00, 1);
    ctl.scan_dr(PAT, word);
    chk_word(word, ID_EXP, "id after system reset");
    give_verdict;
  end
endmodule
